// ### common/pps_pkg.sv
// Constants, register map and types for the panel power sequencer and pin mapper.
// Summary of operation
// - Automatic frame-timed sequencing is used while bit 7 of the mode register is one.
// - In automatic mode every toggle of the display switch outside power-down makes the block step all panel outputs.
// - The two-bit interval field sets the gaps enable-bias, bias-signals and signals-logic supply.
// - Interval codes 00, 01, 10 and 11 give gaps of 1, 2, 4 and 8 vertical frames.
// - The same interval encoding applies to power-off as to power-on.
// - Backlight control stays outside the sequencer; the host may light it with the panel enable.
// - Sequencing runs on entering power-down as well as on display switching.
// - Sync pins are line/frame pulses for DSTN, HSYNC/VSYNC for TFT; data-valid is TFT only.
// - In two-pixel TFT modes channel A carries the first pixel and channel B the second.
// - The upper 12 data bits of the 36-bit TFT mode share pins with video port inputs P11..P0.
package pps_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] PPS_ADDR_SWITCH   = 8'h00;
  localparam logic [7:0] PPS_ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] PPS_ADDR_MODE     = 8'h08;
  localparam logic [7:0] PPS_ADDR_MANUAL   = 8'h0c;
  localparam logic [7:0] PPS_ADDR_STATUS   = 8'h10;
  localparam logic [7:0] PPS_ADDR_PANEL    = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PPS_SWITCH_BIT    = 0;
  localparam int PPS_INTERVAL_LO   = 2;
  localparam int PPS_MODE_AUTO_BIT = 7;
  localparam int PPS_STEP_LOGIC    = 0;
  localparam int PPS_STEP_SIGNALS  = 1;
  localparam int PPS_STEP_BIAS     = 2;
  localparam int PPS_STEP_ENABLE   = 3;
  localparam int PPS_STS_BUSY_BIT  = 4;
  localparam int PPS_STS_PD_BIT    = 5;
  localparam int PPS_STS_ON_BIT    = 6;
  localparam logic [7:0] PPS_MODE_RESET     = 8'h80;
  localparam logic [1:0] PPS_INTERVAL_RESET = 2'h0;
  localparam logic [3:0] PPS_STEPS_OFF      = 4'h0;
  localparam logic [3:0] PPS_STEPS_ALL      = 4'hf;

  // Panel format selections held in the panel register.
  typedef enum logic [2:0] {
    PPS_FMT_DSTN16,
    PPS_FMT_DSTN24,
    PPS_FMT_TFT_SINGLE,
    PPS_FMT_TFT_X2_12,
    PPS_FMT_TFT_X2_18
  } pps_fmt_t;

  localparam logic [2:0] PPS_FMT_RESET = 3'h2;

  // Sequencer states.
  typedef enum logic [1:0] {
    PPS_SEQ_IDLE,
    PPS_SEQ_UP,
    PPS_SEQ_DOWN
  } pps_seq_t;

endpackage : pps_pkg

// ### core/pps_pin_map.sv
// Panel data pin mapper for DSTN, single-pixel TFT and double-pixel TFT modes.
`timescale 1ns/1ps

module pps_pin_map (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire pps_pkg::pps_fmt_t   fmt,
  input  wire logic                signals_on,
  input  wire logic [23:0]         pix_first,
  input  wire logic [23:0]         pix_second,
  output logic      [35:0]         data_out
);
  import pps_pkg::*;

  typedef struct packed {
    logic [35:0] data;
  } pps_map_state_t;

  pps_map_state_t state;
  pps_map_state_t next_state;

  // Pixels arrive as {r[7:0], g[7:0], b[7:0]}; colour groups are placed on the documented pins.
  always_comb begin
    next_state = '0;
    if (signals_on) begin
      unique case (fmt)
        PPS_FMT_DSTN16, PPS_FMT_DSTN24, PPS_FMT_TFT_SINGLE: begin
          // Straight 24-bit placement: red 23:16, green 15:8, blue 7:0.
          next_state.data[23:0] = pix_first;
        end
        PPS_FMT_TFT_X2_12, PPS_FMT_TFT_X2_18: begin
          // First pixel on channel A, second on channel B.
          next_state.data[19:16] = pix_first[19:16];
          next_state.data[23:20] = pix_second[19:16];
          next_state.data[11:8]  = pix_first[11:8];
          next_state.data[15:12] = pix_second[11:8];
          next_state.data[3:0]   = pix_first[3:0];
          next_state.data[7:4]   = pix_second[3:0];
          if (fmt == PPS_FMT_TFT_X2_18) begin
            // Upper bits share the video port pins P11..P0.
            next_state.data[33:32] = pix_first[21:20];
            next_state.data[35:34] = pix_second[21:20];
            next_state.data[29:28] = pix_first[13:12];
            next_state.data[31:30] = pix_second[13:12];
            next_state.data[25:24] = pix_first[5:4];
            next_state.data[27:26] = pix_second[5:4];
          end
        end
        default: next_state.data = '0;
      endcase
    end
  end

  // Registered so every pin leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign data_out = state.data;

endmodule : pps_pin_map

// ### core/pps_sequencer.sv
// Panel power sequencer with APB registers and panel pin drivers.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps

module pps_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_down_req,
  input  wire logic        frame_sync_in,
  input  wire logic        line_sync_in,
  input  wire logic        active_pixel_qualifier,
  input  wire logic        pixel_tick,
  input  wire logic [23:0] pixel_first,
  input  wire logic [23:0] pixel_second,
  output logic             panel_logic_supply_gate,
  output logic             panel_bias_supply_gate,
  output logic             panel_power_enable_out,
  output logic             line_pulse_hsync_pin,
  output logic             frame_pulse_vsync_pin,
  output logic             panel_pixel_strobe,
  output logic             pixel_valid_strobe,
  output logic [35:0]      panel_data_bus
);
  import pps_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        panel_display_switch;
    logic [1:0]  sequence_interval_select;
    logic [7:0]  mode;
    logic [3:0]  manual_power_step_bits;
    logic [2:0]  fmt;
    logic        pd_sync1;
    logic        pd_sync2;
    logic        pd_seen;
    logic        target_on;
    pps_seq_t    seq;
    logic [3:0]  steps;
    logic [3:0]  frames_left;
    logic        fs_sync1;
    logic        fs_sync2;
    logic        fs_last;
    logic        ls_sync1;
    logic        ls_sync2;
    logic        de_sync1;
    logic        de_sync2;
    logic        pt_sync1;
    logic        pt_sync2;
    logic        hsync;
    logic        vsync;
    logic        strobe;
    logic        valid;
    logic [31:0] rdata;
    logic        ready;
  } pps_state_t;

  pps_state_t  state;
  pps_state_t  next_state;
  logic        auto_mode;
  logic        frame_edge;
  logic        want_on;
  logic [3:0]  gap_frames;
  logic [3:0]  live_steps;
  logic        is_tft;
  logic        setup_phase;
  logic        access_done;
  logic        addr_ok;
  logic [35:0] map_data;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  // Mode bit 7 selects automatic sequencing.
  assign auto_mode   = state.mode[PPS_MODE_AUTO_BIT];
  // A new frame begins on the rising edge of the synchronised frame sync.
  assign frame_edge  = state.fs_sync2 && !state.fs_last;
  // Power-down forces the panel off just as clearing the switch does.
  assign want_on     = state.panel_display_switch && !state.pd_seen;
  // Gap of 1, 2, 4 or 8 frames, shared by power-on and power-off.
  assign gap_frames  = 4'h1 << state.sequence_interval_select;
  // The step flops drive the pins in both modes, so every supply pin leaves a flip-flop.
  // The cost is that a software step shows one clock after its register write.
  assign live_steps  = state.steps;
  assign is_tft      = (state.fmt != PPS_FMT_DSTN16) && (state.fmt != PPS_FMT_DSTN24);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && state.ready;
  assign addr_ok     = (paddr == PPS_ADDR_SWITCH) || (paddr == PPS_ADDR_INTERVAL) ||
                       (paddr == PPS_ADDR_MODE) || (paddr == PPS_ADDR_MANUAL) ||
                       (paddr == PPS_ADDR_STATUS) || (paddr == PPS_ADDR_PANEL);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process covers bus, synchronisers, sequencer and pin drivers.
  always_comb begin
    next_state = state;

    // Two-flop synchronisers for all inputs from the video timing and the power manager.
    next_state.pd_sync1 = power_down_req;
    next_state.pd_sync2 = state.pd_sync1;
    next_state.pd_seen  = state.pd_sync2;
    next_state.fs_sync1 = frame_sync_in;
    next_state.fs_sync2 = state.fs_sync1;
    next_state.fs_last  = state.fs_sync2;
    next_state.ls_sync1 = line_sync_in;
    next_state.ls_sync2 = state.ls_sync1;
    next_state.de_sync1 = active_pixel_qualifier;
    next_state.de_sync2 = state.de_sync1;
    next_state.pt_sync1 = pixel_tick;
    next_state.pt_sync2 = state.pt_sync1;

    // APB: answer one cycle after the setup phase, so every access completes with no wait state.
    next_state.ready = setup_phase;
    if (access_done) begin
      next_state.ready = 1'b0;
    end
    if (setup_phase && !pwrite) begin
      next_state.rdata = '0;
      unique case (paddr)
        PPS_ADDR_SWITCH:   next_state.rdata[0] = state.panel_display_switch;
        PPS_ADDR_INTERVAL: next_state.rdata[3:2] = state.sequence_interval_select;
        PPS_ADDR_MODE:     next_state.rdata[7:0] = state.mode;
        PPS_ADDR_MANUAL:   next_state.rdata[3:0] = state.manual_power_step_bits;
        PPS_ADDR_STATUS: begin
          next_state.rdata[3:0]             = live_steps;
          next_state.rdata[PPS_STS_BUSY_BIT] = (state.seq != PPS_SEQ_IDLE);
          next_state.rdata[PPS_STS_PD_BIT]   = state.pd_seen;
          next_state.rdata[PPS_STS_ON_BIT]   = state.target_on;
        end
        PPS_ADDR_PANEL:    next_state.rdata[2:0] = state.fmt;
        default:           next_state.rdata = '0;
      endcase
    end
    if (access_done && pwrite && addr_ok) begin
      unique case (paddr)
        PPS_ADDR_SWITCH:   next_state.panel_display_switch = pwdata[PPS_SWITCH_BIT];
        PPS_ADDR_INTERVAL: next_state.sequence_interval_select =
                             pwdata[PPS_INTERVAL_LO +: 2];
        PPS_ADDR_MODE:     next_state.mode = pwdata[7:0];
        PPS_ADDR_MANUAL:   next_state.manual_power_step_bits = pwdata[3:0];
        PPS_ADDR_PANEL: begin
          if (pwdata[2:0] <= 3'(PPS_FMT_TFT_X2_18)) begin
            next_state.fmt = pwdata[2:0];
          end
        end
        default: ;
      endcase
    end

    // Automatic sequencer: any change of the wanted level starts a walk.
    if (!auto_mode) begin
      next_state.seq   = PPS_SEQ_IDLE;
      next_state.steps = state.manual_power_step_bits;
      next_state.target_on = want_on;
    end else begin
      unique case (state.seq)
        PPS_SEQ_IDLE: begin
          if (want_on != state.target_on) begin
            next_state.target_on   = want_on;
            next_state.frames_left = gap_frames;
            next_state.seq         = want_on ? PPS_SEQ_UP : PPS_SEQ_DOWN;
            if (want_on) begin
              // Logic supply comes up at once, later steps follow a frame gap.
              next_state.steps[PPS_STEP_LOGIC] = 1'b1;
            end else begin
              // Panel enable drops first on the way down.
              next_state.steps[PPS_STEP_ENABLE] = 1'b0;
            end
          end
        end
        PPS_SEQ_UP, PPS_SEQ_DOWN: begin
          if (want_on != state.target_on) begin
            // A reversal mid-walk turns around from the current step.
            next_state.target_on   = want_on;
            next_state.seq         = want_on ? PPS_SEQ_UP : PPS_SEQ_DOWN;
            next_state.frames_left = gap_frames;
          end else if (frame_edge) begin
            if (state.frames_left > 4'h1) begin
              next_state.frames_left = state.frames_left - 4'h1;
            end else begin
              next_state.frames_left = gap_frames;
              if (state.seq == PPS_SEQ_UP) begin
                // Power-on order: logic, signals, bias, enable.
                next_state.steps = {state.steps[2:0], 1'b1};
                if (state.steps[2:0] == 3'h7) begin
                  next_state.seq = PPS_SEQ_IDLE;
                end
              end else begin
                // Power-off order: enable, bias, signals, logic.
                next_state.steps = {1'b0, state.steps[3:1]};
                if (state.steps[3:1] == 3'h0) begin
                  next_state.seq = PPS_SEQ_IDLE;
                end
              end
            end
          end
        end
      endcase
    end

    // Sync pins: line/frame pulse on DSTN, HSYNC/VSYNC on TFT, held low until signals step.
    next_state.hsync  = live_steps[PPS_STEP_SIGNALS] && state.ls_sync2;
    next_state.vsync  = live_steps[PPS_STEP_SIGNALS] && state.fs_sync2;
    next_state.strobe = live_steps[PPS_STEP_SIGNALS] && state.pt_sync2;
    // Data-valid is driven only for TFT formats.
    next_state.valid  = live_steps[PPS_STEP_SIGNALS] && is_tft && state.de_sync2;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                          <= '0;
      state.mode                     <= PPS_MODE_RESET;
      state.sequence_interval_select <= PPS_INTERVAL_RESET;
      state.fmt                      <= PPS_FMT_RESET;
      state.seq                      <= PPS_SEQ_IDLE;
      state.steps                    <= PPS_STEPS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Data pin mapping
  // ----------------------------------------------------------------
  pps_pin_map u_pin_map (
    .pclk       (pclk),
    .presetn    (presetn),
    .fmt        (pps_fmt_t'(state.fmt)),
    .signals_on (live_steps[PPS_STEP_SIGNALS]),
    .pix_first  (pixel_first),
    .pix_second (pixel_second),
    .data_out   (map_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Supply gates come from the step flops; backlight is not driven here.
  assign panel_logic_supply_gate = live_steps[PPS_STEP_LOGIC];
  assign panel_bias_supply_gate  = live_steps[PPS_STEP_BIAS];
  assign panel_power_enable_out  = live_steps[PPS_STEP_ENABLE];
  assign line_pulse_hsync_pin    = state.hsync;
  assign frame_pulse_vsync_pin   = state.vsync;
  assign panel_pixel_strobe      = state.strobe;
  assign pixel_valid_strobe      = state.valid;
  assign panel_data_bus          = map_data;
  assign prdata                  = state.rdata;
  assign pready                  = state.ready;
  assign pslverr                 = 1'b0;

endmodule : pps_sequencer

// ### verification/pps_panel_model.sv
// Behavioural panel with its supply switches and its own backlight.
`timescale 1ns/1ps
module pps_panel_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic logic_gate,
  input  wire logic bias_gate,
  input  wire logic enable_gate,
  output logic      backlight,
  output int        faults
);
  // ----------------------------------------------------------------
  // Supply order log
  // ----------------------------------------------------------------
  logic bias_q;
  logic enable_q;

  // A rail that comes up above an unpowered one would stress the glass, so it is logged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faults    <= 0;
      bias_q    <= 1'b0;
      enable_q  <= 1'b0;
      backlight <= 1'b0;
    end else begin
      bias_q   <= bias_gate;
      enable_q <= enable_gate;
      if ((bias_gate && !bias_q && !logic_gate) || (enable_gate && !enable_q && !bias_gate))
        faults <= faults + 1;
      backlight <= enable_gate;
    end
  end
endmodule : pps_panel_model

// ### verification/pps_properties.sv
// Concurrent checks on the ports of the panel power sequencer.
`timescale 1ns/1ps
module pps_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_sync_in,
  input wire logic        panel_logic_supply_gate,
  input wire logic        panel_bias_supply_gate,
  input wire logic        panel_power_enable_out,
  input wire logic        line_pulse_hsync_pin,
  input wire logic        frame_pulse_vsync_pin,
  input wire logic [35:0] panel_data_bus
);
  // ----------------------------------------------------------------
  // Bus answer, supply ordering and line pulse latency
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A setup cycle opens a transfer; the bias drop starts the tail of a power-off walk.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bias_off;
    $fell(panel_bias_supply_gate);
  endsequence

  a_pready_answer: assert property (s_setup |=> pready)
    else $error("no answer after a setup cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("answer held past one cycle");
  a_slverr_low: assert property (!pslverr)
    else $error("error response raised");
  a_bias_needs_logic: assert property (panel_bias_supply_gate |-> panel_logic_supply_gate)
    else $error("bias supply on without logic supply");
  a_enable_needs_bias: assert property (panel_power_enable_out |-> panel_bias_supply_gate)
    else $error("panel enable on without bias supply");
  a_data_held_low: assert property (|panel_data_bus |-> panel_logic_supply_gate)
    else $error("panel data driven before supply");
  a_sync_held_low: assert property (frame_pulse_vsync_pin |-> panel_logic_supply_gate)
    else $error("frame pulse driven before supply");
  a_hsync_follows_in: assert property ($rose(line_pulse_hsync_pin) |-> $past(line_sync_in, 3))
    else $error("line pulse rose without its input");
  a_logic_off_last: assert property (s_bias_off |=> panel_logic_supply_gate [*2])
    else $error("logic supply dropped with the bias supply");
endmodule : pps_properties

bind pps_sequencer pps_properties pps_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .line_sync_in(line_sync_in),
  .panel_logic_supply_gate(panel_logic_supply_gate),
  .panel_bias_supply_gate(panel_bias_supply_gate),
  .panel_power_enable_out(panel_power_enable_out),
  .line_pulse_hsync_pin(line_pulse_hsync_pin), .frame_pulse_vsync_pin(frame_pulse_vsync_pin),
  .panel_data_bus(panel_data_bus));

// ### verification/pps_sequencer_tb.sv
// Self-checking bench for the panel power sequencer and pin mapper.
`timescale 1ns/1ps
module pps_sequencer_tb;
  import pps_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, model state and instances
  // ----------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic        pd = 0, fsync = 0, lsync = 0, qual = 0, tick = 0;
  logic        lgate, bgate, egate, hs, vs, strobe, valid, light;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h669ccdc5;
  logic [23:0] pix_a = 24'h0, pix_b = 24'h0;
  logic [35:0] bus;
  int          bad_count = 0, compares = 0, faults;
  int          exp_q[$];
  int          sw[8] = '{1, 3, 7, 15, 7, 3, 1, 0};
  int          fm[5] = '{0, 1, 2, 3, 4};

  always #5 pclk = ~pclk;

  pps_sequencer pps_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_req(pd), .frame_sync_in(fsync), .line_sync_in(lsync),
    .active_pixel_qualifier(qual), .pixel_tick(tick), .pixel_first(pix_a),
    .pixel_second(pix_b), .panel_logic_supply_gate(lgate), .panel_bias_supply_gate(bgate),
    .panel_power_enable_out(egate), .line_pulse_hsync_pin(hs), .frame_pulse_vsync_pin(vs),
    .panel_pixel_strobe(strobe), .pixel_valid_strobe(valid), .panel_data_bus(bus));
  pps_panel_model pps_panel_model_i (
    .pclk(pclk), .presetn(presetn), .logic_gate(lgate), .bias_gate(bgate),
    .enable_gate(egate), .backlight(light), .faults(faults));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees an answer.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic cmp_steps(input bit on);
    int e;
    e = exp_q.pop_front();
    chk(36'({egate, bgate, lgate}), 36'({e[3], e[2], e[0]}));
    chk(36'(|bus), 36'(e[1]));
    apb(1'b0, PPS_ADDR_STATUS, 32'h0);
    chk(36'(rd[3:0]), 36'(e));
    chk(36'(rd[PPS_STS_BUSY_BIT]), 36'(exp_q.size() != 0));
    chk(36'(rd[PPS_STS_PD_BIT]), 36'(pd));
    chk(36'(rd[PPS_STS_ON_BIT]), 36'(on));
  endtask : cmp_steps

  // The model walks one step per gap of 1 << code frames; power-off drops the enable at once.
  task automatic walk(input bit on, input int c);
    int n;
    n = 1 << c;
    for (int k = 0; k <= 3 * n; k++)
      exp_q.push_back(on ? 1 | (k >= n) << 1 | (k >= 2 * n) << 2 | (k >= 3 * n) << 3
                         : (k < 3 * n) | (k < 2 * n) << 1 | (k < n) << 2);
    settle(6);
    cmp_steps(on);
    for (int k = 1; k <= 3 * n; k++) begin
      @(posedge pclk) fsync <= 1'b1;
      repeat (3) @(posedge pclk);
      fsync <= 1'b0;
      settle(5);
      cmp_steps(on);
    end
  endtask : walk

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // A hang is cut off well past the fewer than two thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude();
  end

  initial begin
    logic [35:0] e;
    logic [23:0] a, b;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, PPS_ADDR_STATUS, 32'hff);
    apb(1'b1, 8'h1c, 32'hff);
    apb(1'b1, PPS_ADDR_PANEL, 32'h7);
    apb(1'b0, PPS_ADDR_MODE, 32'h0);
    chk(36'(rd), 36'(PPS_MODE_RESET));
    apb(1'b0, PPS_ADDR_STATUS, 32'h0);
    chk(36'(rd), 36'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(36'(rd), 36'h0);
    apb(1'b0, PPS_ADDR_PANEL, 32'h0);
    chk(36'(rd), 36'(PPS_FMT_RESET));
    $display("test registers done");
    pix_a <= 24'(xs()) | 24'h1;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, PPS_ADDR_INTERVAL, 32'(c << 2));
      apb(1'b1, PPS_ADDR_SWITCH, 32'h1);
      walk(1'b1, c);
      apb(1'b1, PPS_ADDR_SWITCH, 32'h0);
      walk(1'b0, c);
    end
    apb(1'b1, PPS_ADDR_INTERVAL, 32'h4);
    apb(1'b1, PPS_ADDR_SWITCH, 32'h1);
    walk(1'b1, 1);
    @(posedge pclk) pd <= 1'b1;
    walk(1'b0, 1);
    @(posedge pclk) pd <= 1'b0;
    walk(1'b1, 1);
    apb(1'b1, PPS_ADDR_SWITCH, 32'h0);
    walk(1'b0, 1);
    $display("test auto walks done");
    // Software mode: shadow timing lives outside this block, so only the mode bit is cleared.
    apb(1'b1, PPS_ADDR_MODE, 32'h0);
    apb(1'b1, PPS_ADDR_SWITCH, 32'h1);
    foreach (sw[i]) begin
      if (i == 4) apb(1'b1, PPS_ADDR_INTERVAL, 32'h8);
      apb(1'b1, PPS_ADDR_MANUAL, 32'(sw[i]));
      settle(2);
      chk(36'({egate, bgate, lgate}), 36'({sw[i][3], sw[i][2], sw[i][0]}));
      chk(36'(|bus), 36'(sw[i][1]));
      chk(36'(light), 36'(sw[i][3]));
      if (i != 3) continue;
      {lsync, fsync, qual, tick} <= 4'hf;
      foreach (fm[j]) begin
        apb(1'b1, PPS_ADDR_PANEL, 32'(fm[j]));
        a = 24'(xs());
        b = 24'(xs());
        pix_a <= a;
        pix_b <= b;
        e = {b[21:20], a[21:20], b[13:12], a[13:12], b[5:4], a[5:4],
             b[19:16], a[19:16], b[11:8], a[11:8], b[3:0], a[3:0]};
        if (fm[j] < 3) e = {12'h0, a};
        if (fm[j] == 3) e[35:24] = 12'h0;
        settle(4);
        chk(bus, e);
        chk(36'({valid, hs, vs, strobe}), 36'({fm[j] > 1, 3'h7}));
      end
      {lsync, fsync, qual, tick} <= 4'h0;
    end
    apb(1'b1, PPS_ADDR_SWITCH, 32'h0);
    chk(36'(faults), 36'h0);
    $display("test software steps and pins done");
    conclude();
  end
endmodule : pps_sequencer_tb
